// ---- logic/smp_pkg.sv ----
// Shared constants and types for the sensor module serial port
package smp_pkg;

  // ----------------------------------------------------------------
  // Clock rates and timing
  // ----------------------------------------------------------------
  localparam longint LINK_CLK_HZ   = 66_666_667;
  localparam longint SCLK_MAX_MHZ  = 1;
  localparam longint LINK_RESET_NS = 1000;
  // Least half period of the serial clock, rounded up
  localparam int HALF_CYC = int'((LINK_CLK_HZ + 2 * SCLK_MAX_MHZ
                                  * 1_000_000 - 1)
                                 / (2 * SCLK_MAX_MHZ * 1_000_000));
  // Least width of the link reset pulse, rounded up
  localparam int LINK_RESET_CYC = int'((LINK_RESET_NS * LINK_CLK_HZ
                                        + 999_999_999) / 1_000_000_000);

  localparam int                CNT_W     = 8;
  localparam logic [CNT_W-1:0]  HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0]  LRST_LAST = CNT_W'(LINK_RESET_CYC - 1);
  localparam logic [CNT_W-1:0]  LRST_LEN  = CNT_W'(LINK_RESET_CYC);

  // ----------------------------------------------------------------
  // Byte framing and buffering
  // ----------------------------------------------------------------
  localparam int          BYTE_W     = 8;
  localparam int          FIFO_DEPTH = 8;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [3:0]  BIT_COUNT  = 4'h8;

  // ----------------------------------------------------------------
  // Pin levels after reset
  // ----------------------------------------------------------------
  localparam logic        SEL_N_IDLE = 1'b1;
  localparam logic        SCLK_IDLE  = 1'b0;
  localparam logic        LRST_IDLE  = 1'b0;
  localparam logic [3:0]  SPARE_IDLE = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              link_reset;
    logic              wait_ready;
    logic              deselect;
    logic [BYTE_W-1:0] data;
  } smp_cmd_t;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_SYNC_HI  = 7'h02,
    ST_SYNC_GAP = 7'h04,
    ST_WAIT_RDY = 7'h08,
    ST_SETUP    = 7'h10,
    ST_SHIFT    = 7'h20,
    ST_DONE     = 7'h40
  } smp_state_t;

endpackage

// ---- logic/smp_port.sv ----
// Serial port master toward a plug-in sensor module, with receive FIFO
//
// How it works
// R1: Serial clock generated here never exceeds 1 MHz.
// R2: Every transfer moves exactly one byte over eight serial clocks.
// R3: Incoming slave data is sampled on the serial clock rising edge.
// R4: Outgoing data changes only on the serial clock falling edge.
// R5: Bytes travel most significant bit first on both lines.
// R6: Select goes low before the first clock and stays low throughout.
// R7: Select may be released after a command byte has been sent.
// R8: Slave floats its data output while select is high.
// R9: Link reset idles low; a low-high-low pulse resets slave serial logic.
// R10: A link reset pulse is issued on startup.
// R11: Module drives result-ready low after a link reset pulse.
// R12: Module raises result-ready once a result can be read.
// R13: For processorless modules wait for result-ready before reading.
// R14: Link reset returns the bit counter to the start of a byte.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Receive FIFO
// ------------------------------------------------------------------
module smp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  logic         clk,
  input  logic         nrst,
  // Fill side
  input  logic         in_valid,
  input  logic [W-1:0] in_data,
  output logic         in_ready,
  // Drain side
  output logic         out_valid,
  output logic [W-1:0] out_data,
  input  logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
    logic [W-1:0]            head;
    logic                    valid;
    logic                    ready;
  } smp_fifo_st_t;

  smp_fifo_st_t r;
  smp_fifo_st_t n;
  logic         push;
  logic         pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    n    = r;
    push = in_valid && r.ready;
    pop  = r.valid && out_ready;
    if (push) begin
      n.mem[r.wr] = in_data;
      n.wr        = ptr_inc(r.wr);
    end
    if (pop) begin
      n.rd = ptr_inc(r.rd);
    end
    n.cnt   = r.cnt + CW'(push) - CW'(pop);
    n.valid = (n.cnt != '0);
    n.ready = (n.cnt != CW'(DEPTH));
    // Head is kept in a register so the drain side sees flop outputs
    n.head  = n.mem[n.rd];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r       <= '0;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready  = r.ready;
  assign out_valid = r.valid;
  assign out_data  = r.head;
endmodule

// ------------------------------------------------------------------
// Port top
// ------------------------------------------------------------------
module smp_port (
  // System clock and reset
  input  logic               clk,
  input  logic               nrst,
  // Link clock
  input  logic               link_clk,
  // Command stream
  input  logic               cmd_valid,
  input  smp_pkg::smp_cmd_t  cmd,
  output logic               cmd_ready,
  // Received bytes
  output logic               rx_valid,
  output logic [7:0]         rx_data,
  input  logic               rx_ready,
  // Sensor module pins
  output logic               sclk,
  output logic               mosi,
  input  logic               miso,
  output logic               module_select_n,
  output logic               link_reset,
  input  logic               module_result_ready,
  output logic               spare_io_0,
  output logic               spare_io_1,
  output logic               spare_io_2,
  output logic               spare_io_3
);
  import smp_pkg::*;

  typedef struct packed {
    smp_cmd_t          hold;
    logic              req;
    logic [2:0]        ack_s;
    logic              ack_f;
    logic              ack_seen;
    logic              busy;
    logic              boot;
    logic              rdy_o;
    logic              push;
    logic [BYTE_W-1:0] pdata;
  } smp_clk_st_t;

  typedef struct packed {
    logic [2:0]        rst_s;
    logic              rst_f;
    logic [2:0]        req_s;
    logic              req_f;
    logic              req_seen;
    logic [2:0]        mi_s;
    logic              mi_f;
    logic [2:0]        dr_s;
    logic              dr_f;
    smp_state_t        st;
    smp_cmd_t          cmd;
    logic [CNT_W-1:0]  cnt;
    logic [2:0]        bits;
    logic [BYTE_W-1:0] tx;
    logic [BYTE_W-1:0] rx;
    logic [BYTE_W-1:0] rx_byte;
    logic              sclk;
    logic              mosi;
    logic              sel_n;
    logic              lrst;
    logic              ack;
    logic [3:0]        spare;
  } smp_link_st_t;

  smp_clk_st_t  c_r;
  smp_clk_st_t  c_n;
  smp_link_st_t l_r;
  smp_link_st_t l_n;
  logic         fifo_in_ready;

  // A change counts once the second and third stages agree
  function automatic logic agree(input logic [2:0] s, input logic f);
    agree = (s[1] == s[2]) ? s[2] : f;
  endfunction

  // ----------------------------------------------------------------
  // System side: hands one command at a time to the link
  // ----------------------------------------------------------------
  always_comb begin
    c_n       = c_r;
    c_n.push  = 1'b0;
    c_n.ack_s = {c_r.ack_s[1:0], l_r.ack};
    c_n.ack_f = agree(c_r.ack_s, c_r.ack_f);
    if (c_r.busy && (c_r.ack_f != c_r.ack_seen)) begin
      // Link is idle now, so its received byte is stable to read
      c_n.ack_seen = c_r.ack_f;
      c_n.busy     = 1'b0;
      c_n.push     = !c_r.hold.link_reset;
      c_n.pdata    = l_r.rx_byte;
    end else if (!c_r.busy && c_r.boot) begin
      c_n.hold            = '0;
      c_n.hold.link_reset = 1'b1; // R10
      c_n.req             = !c_r.req;
      c_n.busy            = 1'b1;
      c_n.boot            = 1'b0;
    end else if (!c_r.busy && cmd_valid && c_r.rdy_o) begin
      c_n.hold = cmd;
      c_n.req  = !c_r.req;
      c_n.busy = 1'b1;
    end
    // Only start a byte when its answer is sure to find room
    c_n.rdy_o = !c_n.busy && !c_n.boot && fifo_in_ready
                && !c_n.push && !c_r.push;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      c_r      <= '0;
      c_r.boot <= 1'b1;
    end else begin
      c_r <= c_n;
    end
  end

  smp_fifo #(
    .W     (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (c_r.push),
    .in_data   (c_r.pdata),
    .in_ready  (fifo_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // ----------------------------------------------------------------
  // Link side: drives the serial pins from the link clock
  // ----------------------------------------------------------------
  always_comb begin
    l_n       = l_r;
    l_n.rst_s = {l_r.rst_s[1:0], nrst};
    l_n.rst_f = agree(l_r.rst_s, l_r.rst_f);
    l_n.req_s = {l_r.req_s[1:0], c_r.req};
    l_n.req_f = agree(l_r.req_s, l_r.req_f);
    l_n.mi_s  = {l_r.mi_s[1:0], miso};
    l_n.mi_f  = agree(l_r.mi_s, l_r.mi_f);
    l_n.dr_s  = {l_r.dr_s[1:0], module_result_ready};
    l_n.dr_f  = agree(l_r.dr_s, l_r.dr_f);
    if (!l_r.rst_f) begin
      l_n.req_seen = 1'b0;
      l_n.st       = ST_IDLE;
      l_n.cnt      = '0;
      l_n.bits     = '0;
      l_n.sclk     = SCLK_IDLE;
      l_n.mosi     = 1'b0;
      l_n.sel_n    = SEL_N_IDLE;
      l_n.lrst     = LRST_IDLE;
      l_n.ack      = 1'b0;
      l_n.spare    = SPARE_IDLE;
    end else begin
      case (l_r.st)
        ST_IDLE: begin
          if (l_r.req_f != l_r.req_seen) begin
            // Command word has been stable for several cycles here
            l_n.req_seen = l_r.req_f;
            l_n.cmd      = c_r.hold;
            l_n.cnt      = '0;
            if (c_r.hold.link_reset) begin
              l_n.sel_n = 1'b1;
              l_n.sclk  = 1'b0;
              l_n.lrst  = 1'b1; // R9
              l_n.bits  = '0;   // R14
              l_n.st    = ST_SYNC_HI;
            end else if (c_r.hold.wait_ready) begin
              l_n.st = ST_WAIT_RDY;
            end else begin
              l_n.st = ST_SETUP;
            end
          end
        end
        ST_SYNC_HI: begin
          l_n.cnt = l_r.cnt + 1'b1;
          if (l_r.cnt == LRST_LAST) begin
            l_n.lrst = 1'b0; // R9
            l_n.cnt  = '0;
            l_n.st   = ST_SYNC_GAP;
          end
        end
        ST_SYNC_GAP: begin
          // Give the slave time to settle before any next select
          l_n.cnt = l_r.cnt + 1'b1;
          if (l_r.cnt == LRST_LAST) begin
            l_n.st = ST_DONE;
          end
        end
        ST_WAIT_RDY: begin
          // No timeout: a module that never answers stalls the port
          if (l_r.dr_f) begin // R13 R12
            l_n.st = ST_SETUP;
          end
        end
        ST_SETUP: begin
          l_n.sel_n = 1'b0;              // R6
          l_n.tx    = l_r.cmd.data;
          l_n.mosi  = l_r.cmd.data[7];   // R5
          l_n.bits  = '0;
          l_n.cnt   = l_r.cnt + 1'b1;
          if (l_r.cnt == HALF_LAST) begin
            l_n.cnt = '0;
            l_n.st  = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          l_n.cnt = l_r.cnt + 1'b1;
          if (l_r.cnt == HALF_LAST) begin // R1
            l_n.cnt = '0;
            if (!l_r.sclk) begin
              l_n.sclk = 1'b1;
              l_n.rx   = {l_r.rx[6:0], l_r.mi_f}; // R3 R8
            end else begin
              l_n.sclk = 1'b0;
              if (l_r.bits == LAST_BIT) begin // R2
                l_n.st = ST_DONE;
              end else begin
                l_n.bits = l_r.bits + 1'b1;
                l_n.tx   = {l_r.tx[6:0], 1'b0};
                l_n.mosi = l_r.tx[6]; // R4 R5
              end
            end
          end
        end
        ST_DONE: begin
          l_n.rx_byte = l_r.rx;
          if (l_r.cmd.deselect) begin
            l_n.sel_n = 1'b1; // R7
          end
          l_n.ack = !l_r.ack;
          l_n.st  = ST_IDLE;
        end
        default: begin
          l_n.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    l_r <= l_n;
  end

  assign cmd_ready       = c_r.rdy_o;
  assign sclk            = l_r.sclk;
  assign mosi            = l_r.mosi;
  assign module_select_n = l_r.sel_n;
  assign link_reset      = l_r.lrst;
  assign spare_io_0      = l_r.spare[0];
  assign spare_io_1      = l_r.spare[1];
  assign spare_io_2      = l_r.spare[2];
  assign spare_io_3      = l_r.spare[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] hold_cnt;
  logic [3:0] rise_cnt;
  logic [7:0] pulse_cnt;

  // Cleared while the link side is held in reset so the first phase is not measured from X
  always_ff @(posedge link_clk) begin
    if (!l_r.rst_f) begin
      hold_cnt  <= '0;
      rise_cnt  <= '0;
      pulse_cnt <= '0;
    end else begin
      hold_cnt  <= (l_n.sclk != l_r.sclk) ? '0
                 : (hold_cnt == 8'hFF) ? hold_cnt : hold_cnt + 1'b1;
      rise_cnt  <= (l_r.st == ST_SETUP) ? '0
                 : (l_n.sclk && !l_r.sclk) ? rise_cnt + 1'b1 : rise_cnt;
      pulse_cnt <= l_r.lrst ? pulse_cnt + 1'b1 : '0;
    end
  end

  property p_sclk_rate;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    (l_n.sclk != l_r.sclk) |-> (hold_cnt >= 8'(HALF_LAST));
  endproperty
  a_sclk_rate: assert property (p_sclk_rate) // R1
    else $error("serial clock phase shorter than half period");

  property p_eight_clocks;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    (l_r.st == ST_SHIFT && l_n.st == ST_DONE) |-> (rise_cnt == BIT_COUNT);
  endproperty
  a_eight_clocks: assert property (p_eight_clocks) // R2
    else $error("byte did not take eight serial clocks");

  property p_sample_rise;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    $rose(l_r.sclk) |-> (l_r.rx[0] == $past(l_r.mi_f));
  endproperty
  a_sample_rise: assert property (p_sample_rise) // R3
    else $error("input bit not captured at rising edge");

  property p_mosi_on_fall;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    (!l_r.sel_n && $changed(l_r.mosi) && l_r.st != ST_SETUP)
      |-> $fell(l_r.sclk);
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall) // R4
    else $error("output data changed away from falling edge");

  property p_msb_first;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    ($fell(l_r.sclk) && l_r.st == ST_SHIFT)
      |-> (l_r.mosi == l_r.cmd.data[LAST_BIT - l_r.bits]);
  endproperty
  a_msb_first: assert property (p_msb_first) // R5
    else $error("output bit out of order");

  property p_select_held;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    (l_r.st == ST_SHIFT || l_r.sclk) |-> !l_r.sel_n;
  endproperty
  a_select_held: assert property (p_select_held) // R6
    else $error("select high during transfer");

  property p_release;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    $rose(l_r.sel_n)
      |-> (($past(l_r.st) == ST_DONE && l_r.cmd.deselect) || l_r.lrst);
  endproperty
  a_release: assert property (p_release) // R7
    else $error("select released outside byte end");

  property p_pulse_width;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    $fell(l_r.lrst) |-> (pulse_cnt == LRST_LEN);
  endproperty
  a_pulse_width: assert property (p_pulse_width) // R9
    else $error("link reset pulse width wrong");

  property p_boot_reset;
    @(posedge clk) disable iff (!nrst)
    $rose(nrst) |=> (c_r.busy && c_r.hold.link_reset);
  endproperty
  a_boot_reset: assert property (p_boot_reset) // R10
    else $error("startup link reset not issued");

  property p_wait_ready;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    (l_r.st == ST_WAIT_RDY && !l_r.dr_f) |=> (l_r.st == ST_WAIT_RDY);
  endproperty
  a_wait_ready: assert property (p_wait_ready) // R13
    else $error("left wait before result ready");

  property p_realign;
    @(posedge link_clk) disable iff (!l_r.rst_f)
    $fell(l_r.lrst) |-> (l_r.bits == '0 && !l_r.sclk && l_r.sel_n);
  endproperty
  a_realign: assert property (p_realign) // R14
    else $error("bit counter not aligned after link reset");
endmodule

// ---- test/smp_sensor_model.sv ----
// Behavioural sensor module on the far side of the serial port
`timescale 1ns/1ps
module smp_sensor_model (
  // Serial pins
  input  logic       sclk,
  input  logic       mosi,
  output logic       miso,
  input  logic       module_select_n,
  input  logic       link_reset,
  output logic       module_result_ready,
  // Bench side
  input  logic [7:0] reply,
  input  int         rdy_delay,
  output logic [7:0] got_byte,
  output int         got_cnt
);
  logic [7:0] out_sh = 8'h00;
  logic [7:0] in_sh  = 8'h00;
  logic       flt    = 1'b0;
  int         bitn   = 0;
  initial got_cnt = 0;
  initial module_result_ready = 1'b0;
  // Released line shows the inverse of its last bit, never a held value
  assign miso = module_select_n ? flt
              : (bitn == 0 ? reply[7] : out_sh[7]);
  always @(posedge module_select_n)
    flt = ~(bitn == 0 ? reply[7] : out_sh[7]);
  always @(posedge link_reset) begin
    bitn = 0;
    module_result_ready = 1'b0;
  end
  always @(posedge sclk) if (module_select_n === 1'b0) begin
    if (bitn == 0) begin
      out_sh = reply;
      module_result_ready = 1'b0;
    end
    in_sh = {in_sh[6:0], mosi};
    bitn = (bitn + 1) % 8;
    if (bitn == 0) begin
      got_byte = in_sh;
      got_cnt++;
      fork
        #(rdy_delay) module_result_ready = 1'b1;
      join_none
    end
  end
  always @(negedge sclk)
    if (module_select_n === 1'b0 && bitn != 0) out_sh = out_sh << 1;
endmodule

// ---- test/smp_port_tb.sv ----
// Self-checking bench for the sensor module serial port
`timescale 1ns/1ps
module smp_port_tb;
  import smp_pkg::*;
  // ------------------------------------------------------------
  // Signals, clocks, design and partner
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid, cmd_ready, rx_valid, rx_ready;
  smp_cmd_t    cmd;
  logic [7:0]  rx_data, reply, got_byte;
  logic        sclk, mosi, miso, module_select_n, link_reset;
  logic        module_result_ready;
  logic [3:0]  spare;
  int          rdy_delay, got_cnt, err_total, checks, lr_cnt, lrw, bits, wn;
  logic        wr = 1'b0;
  realtime     t_rise;
  logic        mo, mo_hi;
  logic [31:0] seed = 32'hb1b5_5073;
  int          eq[$];
  int          mq[$];
  always #10 clk = ~clk;
  always #7.5 link_clk = ~link_clk;
  smp_port dut_u (.clk(clk), .nrst(nrst), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .sclk(sclk), .mosi(mosi), .miso(miso),
    .module_select_n(module_select_n), .link_reset(link_reset),
    .module_result_ready(module_result_ready), .spare_io_0(spare[0]),
    .spare_io_1(spare[1]), .spare_io_2(spare[2]), .spare_io_3(spare[3]));
  smp_sensor_model part_u (.sclk(sclk), .mosi(mosi), .miso(miso),
    .module_select_n(module_select_n), .link_reset(link_reset),
    .module_result_ready(module_result_ready), .reply(reply),
    .rdy_delay(rdy_delay), .got_byte(got_byte), .got_cnt(got_cnt));
  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1) begin
      n++;
      if (n > 5000) begin
        err_total++;
        finish_test;
      end
      @(negedge clk);
    end
  endtask
  // Ready was seen high at this falling edge, so the next rise takes it
  task put(input logic [7:0] d, input logic ds, input logic w,
           input logic lr);
    wait_rdy;
    seed = lfsr_next(seed);
    reply = seed[15:8];
    if (!lr) begin
      eq.push_back(reply);
      mq.push_back(d);
    end
    cmd = '{link_reset: lr, wait_ready: w, deselect: ds, data: d};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task pull;
    int n;
    n = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && n < 5000) begin
      n++;
      @(negedge clk);
    end
    if (n >= 5000) begin
      err_total++;
      finish_test;
    end
    chk(rx_data, eq.pop_front());
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Pin monitors
  // ------------------------------------------------------------
  always @(posedge sclk) if (nrst) begin
    t_rise = $realtime;
    mo = mosi;
    bits++;
    chk(module_select_n, 1'b0);
  end
  // Last settled level of the high phase; the fall itself may move mosi
  always @(negedge link_clk) if (sclk === 1'b1) mo_hi = mosi;
  always @(negedge sclk) if (nrst) begin
    chk($realtime - t_rise >= 500.0, 1'b1);
    chk(mo_hi, mo);
  end
  always @(posedge module_select_n) if (nrst) chk(bits % 8, 0);
  always @(negedge module_select_n)
    if (wr) chk(module_result_ready, 1'b1);
  always @(posedge link_clk) if (link_reset === 1'b1) lrw++;
  always @(posedge link_reset) if (nrst) chk(module_select_n, 1'b1);
  always @(negedge link_reset) if (nrst) begin
    chk(lrw, LINK_RESET_CYC);
    lrw = 0;
    lr_cnt++;
  end
  always @(got_cnt) if (got_cnt > 0) chk(got_byte, mq.pop_front());
  initial begin
    #2_000_000;
    err_total++;
    finish_test;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {err_total, checks, lr_cnt, lrw, bits, rdy_delay} = '0;
    cmd_valid = 1'b0;
    cmd = '0;
    rx_ready = 1'b0;
    reply = 8'h00;
    // Longer than three cycles so the link side sees reset too
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    wait_rdy;
    chk(lr_cnt, 1);
    chk(spare, 4'h0);
    $display("test boot done");
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      seed = lfsr_next(seed);
      put(seed[7:0], seed[16], 1'b0, 1'b0);
    end
    repeat (1500) @(negedge clk);
    chk(cmd_ready, 1'b0);
    repeat (FIFO_DEPTH) pull;
    chk(rx_valid, 1'b0);
    $display("test fifo fill done");
    rdy_delay = 4000;
    put(8'ha5, 1'b1, 1'b0, 1'b0);
    wait_rdy;
    wr = 1'b1;
    put(8'h3c, 1'b1, 1'b1, 1'b0);
    pull;
    pull;
    wait_rdy;
    wr = 1'b0;
    rdy_delay = 0;
    $display("test wait ready done");
    // Let the pending result flag rise so the link reset must clear it
    wn = 0;
    while (module_result_ready !== 1'b1 && wn < 1000) begin
      wn++;
      @(negedge clk);
    end
    chk(module_result_ready, 1'b1);
    put(8'h00, 1'b1, 1'b0, 1'b1);
    wait_rdy;
    chk(lr_cnt, 2);
    chk(module_result_ready, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      put(seed[7:0], i[0], 1'b0, 1'b0);
      pull;
    end
    $display("test link reset done");
    finish_test;
  end
endmodule
